/* File: rtl/bank_map_pkg.sv */
package bank_map_pkg;
  localparam logic [7:0]  BANK_SEL_ADDR     = 8'hB1;
  localparam logic [7:0]  BANK_SEL_RESET    = 8'h11;
  localparam int          FETCH_LSB         = 0;
  localparam int          CONST_LSB         = 4;
  localparam logic [7:0]  BANK_SEL_MASK     = 8'h33;
  localparam logic [16:0] RESERVED_FIRST    = 17'h1_FC00;
  localparam logic [16:0] RESERVED_LAST     = 17'h1_FFFF;
  localparam logic [16:0] SCRATCH_BASE      = 17'h0_0000;
  localparam int          BANK_COUNT        = 4;
  localparam int          BANK_BYTES        = 32768;
  localparam int          FLASH_BYTES       = BANK_COUNT * BANK_BYTES;

  typedef enum logic [1:0] {
    ACC_FETCH = 2'b00,
    ACC_CONST = 2'b01,
    ACC_WRITE = 2'b10,
    ACC_DREAD = 2'b11
  } access_kind_t;
endpackage

/* File: rtl/bank_map_if.sv */
`timescale 1ns/100ps
interface bank_map_if;
  logic [1:0]  bank;
  logic [15:0] addr;
  logic        scratch;
  logic [16:0] linear;
  logic        reserved;
  modport user (output bank, addr, scratch, input linear, reserved);
  modport calc (input bank, addr, scratch, output linear, reserved);
endinterface

/* File: rtl/bank_addr_calc.sv */
`timescale 1ns/100ps
module bank_addr_calc
  import bank_map_pkg::*;
(
  bank_map_if.calc port
);
  // Lower half always uses bank 0; scratch accesses bypass the bank field.
  always_comb begin
    if (port.scratch) begin
      port.linear = SCRATCH_BASE | {7'h00, port.addr[9:0]};
    end else if (!port.addr[15]) begin
      port.linear = {2'b00, port.addr[14:0]};
    end else begin
      port.linear = {port.bank, port.addr[14:0]};
    end
    port.reserved = !port.scratch && port.linear >= RESERVED_FIRST && port.linear <= RESERVED_LAST;
  end
endmodule

/* File: rtl/code_bank_address_mapper.sv */
`timescale 1ns/100ps
module code_bank_address_mapper
  import bank_map_pkg::*;
(
  input  wire logic         mclk_in,
  input  wire logic         reset_n_in,
  input  wire logic         sfr_wr_in,
  input  wire logic         sfr_rd_in,
  input  wire logic [7:0]   sfr_addr_in,
  input  wire logic [7:0]   sfr_wdata_in,
  input  wire logic         writer_in_bank0_in,
  input  wire logic         req_in,
  input  wire access_kind_t kind_in,
  input  wire logic [15:0]  addr_in,
  input  wire logic         scratch_in,
  input  wire logic         store_write_enable_in,
  output logic [7:0]        sfr_rdata_out,
  output logic              sfr_hit_out,
  output logic [16:0]       flash_addr_out,
  output logic              flash_rd_out,
  output logic              flash_wr_out,
  output logic              xdata_wr_out,
  output logic              reserved_err_out
);
  typedef struct packed {
    logic [1:0]  fetch_bank_field;
    logic [1:0]  constant_bank_field;
    logic [7:0]  rdata;
    logic        hit;
    logic [16:0] faddr;
    logic        frd;
    logic        fwr;
    logic        xwr;
    logic        rerr;
  } state_t;

  state_t st;
  state_t next_st;
  bank_map_if calc_bus ();
  logic sel;
  logic is_fetch;

  bank_addr_calc u_calc (
    .port (calc_bus.calc)
  );

  assign sel      = (sfr_addr_in == BANK_SEL_ADDR);
  assign is_fetch = (kind_in == ACC_FETCH);
  assign calc_bus.addr    = addr_in;
  assign calc_bus.scratch = scratch_in && !is_fetch;
  assign calc_bus.bank    = is_fetch ? st.fetch_bank_field : st.constant_bank_field;

  always_comb begin
    next_st = st;
    next_st.hit = sel && (sfr_rd_in || sfr_wr_in);
    next_st.rdata = 8'h00;
    if (sel && sfr_rd_in) begin
      next_st.rdata = {2'b00, st.constant_bank_field, 2'b00, st.fetch_bank_field};
    end
    if (sel && sfr_wr_in) begin
      next_st.constant_bank_field = sfr_wdata_in[CONST_LSB +: 2];
      if (writer_in_bank0_in) begin
        next_st.fetch_bank_field = sfr_wdata_in[FETCH_LSB +: 2];
      end
    end
    next_st.faddr = calc_bus.linear;
    next_st.rerr  = req_in && calc_bus.reserved;
    next_st.frd   = req_in && !calc_bus.reserved && kind_in != ACC_WRITE;
    next_st.fwr   = req_in && !calc_bus.reserved && kind_in == ACC_WRITE && store_write_enable_in;
    next_st.xwr   = req_in && kind_in == ACC_WRITE && !store_write_enable_in;
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st <= '{fetch_bank_field: BANK_SEL_RESET[1:0], constant_bank_field: BANK_SEL_RESET[5:4], default: '0};
    end else begin
      st <= next_st;
    end
  end

  assign sfr_rdata_out    = st.rdata;
  assign sfr_hit_out      = st.hit;
  assign flash_addr_out   = st.faddr;
  assign flash_rd_out     = st.frd;
  assign flash_wr_out     = st.fwr;
  assign xdata_wr_out     = st.xwr;
  assign reserved_err_out = st.rerr;

  a_low_half_bank0: assert property (
    @(posedge mclk_in) disable iff (!reset_n_in)
    req_in && !scratch_in && !addr_in[15]
    |=> flash_addr_out[16:15] == 2'b00
  ) else $error("Low half access left bank 0.");

  a_fetch_low_half: assert property (
    @(posedge mclk_in) disable iff (!reset_n_in)
    req_in && is_fetch && !addr_in[15]
    |=> flash_addr_out == {2'b00, $past(addr_in[14:0])}
  ) else $error("Low half fetch did not pass its offset.");

  a_bank_range: assert property (
    @(posedge mclk_in) disable iff (!reset_n_in)
    req_in && !calc_bus.scratch && addr_in[15]
    |=> flash_addr_out[14:0] == $past(addr_in[14:0])
  ) else $error("Upper half offset was altered.");

  a_fetch_bank_map: assert property (
    @(posedge mclk_in) disable iff (!reset_n_in)
    req_in && is_fetch && addr_in[15]
    |=> flash_addr_out[16:15] == $past(st.fetch_bank_field)
  ) else $error("Upper fetch used the wrong bank.");

  a_const_bank_map: assert property (
    @(posedge mclk_in) disable iff (!reset_n_in)
    req_in && kind_in == ACC_CONST && !scratch_in && addr_in[15]
    |=> flash_addr_out == {$past(st.constant_bank_field), $past(addr_in[14:0])}
  ) else $error("Upper constant read used the wrong bank.");

  a_const_write: assert property (
    @(posedge mclk_in) disable iff (!reset_n_in)
    sel && sfr_wr_in
    |=> st.constant_bank_field == $past(sfr_wdata_in[CONST_LSB +: 2])
  ) else $error("Constant bank write was lost.");

  a_scratch_no_bank: assert property (
    @(posedge mclk_in) disable iff (!reset_n_in)
    req_in && !is_fetch && scratch_in
    |=> flash_addr_out[16:10] == SCRATCH_BASE[16:10]
  ) else $error("Scratch access took a bank.");

  a_scratch_not_reserved: assert property (
    @(posedge mclk_in) disable iff (!reset_n_in)
    req_in && calc_bus.scratch
    |=> !reserved_err_out
  ) else $error("Scratch access was flagged reserved.");

  a_fetch_write_bank0: assert property (
    @(posedge mclk_in) disable iff (!reset_n_in)
    sel && sfr_wr_in && writer_in_bank0_in
    |=> st.fetch_bank_field == $past(sfr_wdata_in[FETCH_LSB +: 2])
  ) else $error("Fetch bank write from bank 0 was lost.");

  a_fetch_bank_hold: assert property (
    @(posedge mclk_in) disable iff (!reset_n_in)
    !writer_in_bank0_in
    |=> $stable(st.fetch_bank_field)
  ) else $error("Fetch bank changed from an upper bank.");

  a_reg_any_page: assert property (
    @(posedge mclk_in) disable iff (!reset_n_in)
    sfr_rd_in && sfr_addr_in == BANK_SEL_ADDR
    |=> sfr_hit_out
  ) else $error("Bank select read gave no hit.");

  a_other_addr_quiet: assert property (
    @(posedge mclk_in) disable iff (!reset_n_in)
    sfr_addr_in != BANK_SEL_ADDR
    |=> !sfr_hit_out && sfr_rdata_out == 8'h00
  ) else $error("Other register address gave an answer.");

  a_reserved_flag: assert property (
    @(posedge mclk_in) disable iff (!reset_n_in)
    req_in && !is_fetch && !scratch_in && addr_in[15]
    && addr_in[14:10] == RESERVED_FIRST[14:10] && st.constant_bank_field == RESERVED_FIRST[16:15]
    |=> reserved_err_out
  ) else $error("Reserved area was not flagged.");

  a_reserved_block: assert property (
    @(posedge mclk_in) disable iff (!reset_n_in)
    reserved_err_out
    |-> !flash_rd_out && !flash_wr_out
  ) else $error("Reserved area was accessed.");

  a_write_enable: assert property (
    @(posedge mclk_in) disable iff (!reset_n_in)
    req_in && kind_in == ACC_WRITE && !store_write_enable_in
    |=> !flash_wr_out && xdata_wr_out
  ) else $error("Disabled store write reached flash.");

  a_flash_write_gate: assert property (
    @(posedge mclk_in) disable iff (!reset_n_in)
    req_in && kind_in == ACC_WRITE && store_write_enable_in && !calc_bus.reserved
    |=> flash_wr_out && !xdata_wr_out
  ) else $error("Enabled store write missed flash.");

  a_write_strobe_src: assert property (
    @(posedge mclk_in) disable iff (!reset_n_in)
    flash_wr_out
    |-> $past(req_in) && $past(store_write_enable_in) && $past(kind_in) == ACC_WRITE
  ) else $error("Flash write without an enabled store write.");

  a_no_read_write: assert property (
    @(posedge mclk_in) disable iff (!reset_n_in)
    req_in && kind_in == ACC_WRITE
    |=> !flash_rd_out
  ) else $error("Store write raised a flash read.");

  a_idle_no_strobe: assert property (
    @(posedge mclk_in) disable iff (!reset_n_in)
    !req_in
    |=> !flash_rd_out && !flash_wr_out && !xdata_wr_out && !reserved_err_out
  ) else $error("Strobe without a request.");

  a_reserved_zero: assert property (
    @(posedge mclk_in) disable iff (!reset_n_in)
    ##1 (sfr_rdata_out & ~BANK_SEL_MASK) == 8'h00
  ) else $error("Reserved bits read as one.");

  a_read_value: assert property (
    @(posedge mclk_in) disable iff (!reset_n_in)
    sel && sfr_rd_in
    |=> sfr_rdata_out == {2'b00, $past(st.constant_bank_field), 2'b00, $past(st.fetch_bank_field)}
  ) else $error("Bank select read gave the wrong value.");
endmodule

/* File: tb/core_model.sv */
`timescale 1ns/100ps
module core_model
  import bank_map_pkg::*;
(
  input  wire logic    mclk_in,
  output logic         req_out,
  output access_kind_t kind_out,
  output logic [15:0]  addr_out,
  output logic         scratch_out
);
  initial begin
    req_out = 1'b0;
    kind_out = ACC_FETCH;
    addr_out = 16'h0000;
    scratch_out = 1'b0;
  end
  // Holds one access for one cycle, then scrambles the idle address.
  task automatic go(input access_kind_t k, input logic [15:0] a, input logic s);
    @(negedge mclk_in);
    req_out = 1'b1;
    kind_out = k;
    addr_out = a;
    scratch_out = s;
    @(negedge mclk_in);
    req_out = 1'b0;
    addr_out = ~a;
  endtask
endmodule

/* File: tb/tb.sv */
`timescale 1ns/100ps
module tb;
  import bank_map_pkg::*;
  logic mclk = 0, rst_n = 0, wr = 0, rd = 0, b0 = 1, swe = 0;
  logic [7:0] wd = 8'h00, sa = 8'h00, rdat;
  logic [16:0] fa;
  logic hit, frd, fwr, xwr, rerr, req, sc;
  access_kind_t kd;
  logic [15:0] ad;
  int fails = 0, total_checks = 0;
  always #20 mclk = ~mclk;
  core_model u_core (.mclk_in(mclk), .req_out(req), .kind_out(kd), .addr_out(ad), .scratch_out(sc));
  code_bank_address_mapper u_dut (.mclk_in(mclk), .reset_n_in(rst_n), .sfr_wr_in(wr), .sfr_rd_in(rd),
    .sfr_addr_in(sa), .sfr_wdata_in(wd), .writer_in_bank0_in(b0), .req_in(req), .kind_in(kd),
    .addr_in(ad), .scratch_in(sc), .store_write_enable_in(swe), .sfr_rdata_out(rdat),
    .sfr_hit_out(hit), .flash_addr_out(fa), .flash_rd_out(frd), .flash_wr_out(fwr),
    .xdata_wr_out(xwr), .reserved_err_out(rerr));
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic sfr(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    wr = w;
    rd = !w;
    sa = a;
    wd = d;
    @(negedge mclk);
    wr = 0;
    rd = 0;
  endtask
  task automatic summarize();
    if (fails == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic t_regs();
    sfr(0, BANK_SEL_ADDR, 8'h00);
    chk({hit, rdat}, {1'b1, 8'h11});
    sfr(0, 8'hB0, 8'h00);
    chk({hit, rdat}, 9'h000);
  endtask
  task automatic t_banks();
    for (int b = 0; b < 4; b++) begin
      sfr(1, BANK_SEL_ADDR, {2'b00, 2'(3 - b), 2'b00, 2'(b)});
      u_core.go(ACC_FETCH, 16'h8004, 1'b0);
      chk({frd, fa}, {1'b1, 2'(b), 15'h0004});
      u_core.go(ACC_CONST, 16'h9ABC, 1'b0);
      chk({frd, fa}, {1'b1, 2'(3 - b), 15'h1ABC});
      u_core.go(ACC_DREAD, 16'h7FFF, 1'b0);
      chk(fa, 17'h0_7FFF);
      u_core.go(ACC_FETCH, 16'h0123, 1'b0);
      chk({frd, fa}, {1'b1, 17'h0_0123});
    end
  endtask
  task automatic t_guard();
    b0 = 0;
    sfr(1, BANK_SEL_ADDR, 8'hEE);
    sfr(0, BANK_SEL_ADDR, 8'h00);
    chk(rdat, 8'h23);
    b0 = 1;
    sfr(1, BANK_SEL_ADDR, 8'hCC);
    sfr(0, BANK_SEL_ADDR, 8'h00);
    chk(rdat, 8'h00);
  endtask
  task automatic t_flash();
    sfr(1, BANK_SEL_ADDR, 8'h30);
    u_core.go(ACC_WRITE, 16'h8010, 1'b0);
    chk({fwr, xwr}, 2'b01);
    swe = 1;
    u_core.go(ACC_WRITE, 16'h8010, 1'b0);
    chk({fwr, xwr, fa}, {2'b10, 17'h1_8010});
    u_core.go(ACC_CONST, 16'hFC05, 1'b0);
    chk({frd, rerr}, 2'b01);
    u_core.go(ACC_WRITE, 16'hFC05, 1'b1);
    chk({fwr, rerr, fa}, {2'b10, 17'h0_0005});
  endtask
  task automatic t_reset();
    sfr(1, BANK_SEL_ADDR, 8'h22);
    u_core.go(ACC_FETCH, 16'h8001, 1'b0);
    chk({frd, fa}, {1'b1, 17'h1_0001});
    rst_n = 0;
    @(negedge mclk);
    chk({hit, rdat, frd, fwr, xwr, rerr}, 13'h0000);
    chk(fa, 17'h0_0000);
    rst_n = 1;
    u_core.go(ACC_FETCH, 16'h8001, 1'b0);
    chk({frd, fa}, {1'b1, BANK_SEL_RESET[FETCH_LSB +: 2], 15'h0001});
    sfr(0, BANK_SEL_ADDR, 8'h00);
    chk({hit, rdat}, {1'b1, BANK_SEL_RESET});
  endtask
  initial begin
    repeat (6) @(negedge mclk);
    rst_n = 1;
    t_regs();
    t_banks();
    t_guard();
    t_flash();
    t_reset();
    summarize();
  end
  initial begin
    #20000;
    fails++;
    summarize();
  end
endmodule
